// >>> src/fpb_pkg.sv
// Constants, state encoding and state record of the flyback PWM and burst control core
package fpb_pkg;

  // Clock and switching rates
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned NOM_HZ_100   = 100_000;
  localparam int unsigned NOM_HZ_125   = 125_000;
  localparam int unsigned BURST_HZ_100 = 83_000;
  localparam int unsigned BURST_HZ_125 = 103_000;
  localparam logic [15:0] NOM_PER_100   = 16'(CLK_HZ / NOM_HZ_100);
  localparam logic [15:0] NOM_PER_125   = 16'(CLK_HZ / NOM_HZ_125);
  localparam logic [15:0] BURST_PER_100 = 16'(CLK_HZ / BURST_HZ_100);
  localparam logic [15:0] BURST_PER_125 = 16'(CLK_HZ / BURST_HZ_125);

  // Duty limit as a fraction, thresholds in percent of the period
  localparam int unsigned MAX_DUTY_NUM = 3;
  localparam int unsigned MAX_DUTY_DEN = 4;
  localparam int unsigned SLOPE_PCT    = 40;
  localparam int unsigned CURVE_PCT    = 40;

  // Jitter: total span and repeat time
  localparam int unsigned JIT_HALF_PCT  = 4;
  localparam int unsigned JIT_SPAN_PCT  = 2 * JIT_HALF_PCT;
  localparam int unsigned JIT_PERIOD_MS = 4;
  localparam logic [5:0]  TRI_MAX       = 6'h3F;
  // A full triangle is 2 * TRI_MAX steps, so the step length is set from that count
  localparam int unsigned JIT_STEP_CYC  = CLK_HZ / 1000 * JIT_PERIOD_MS / (2 * int'(TRI_MAX));

  // Soft-start
  localparam int unsigned SS_TIME_MS  = 12;
  localparam int unsigned SS_STEPS    = 4;
  localparam int unsigned SS_STEP_CYC = CLK_HZ / 1000 * SS_TIME_MS / SS_STEPS;
  localparam logic [1:0]  SS_LAST     = 2'(SS_STEPS - 1);

  // Feedback code scale and levels in millivolts
  localparam int unsigned FB_LSB_MV   = 20;
  localparam int unsigned FR_START_MV = 1700;
  localparam int unsigned ENTRY_LP_MV = 930;
  localparam int unsigned ENTRY_HP_MV = 1030;
  localparam int unsigned LEAVE_MV    = 2730;
  localparam logic [7:0]  FR_START_CODE = 8'(FR_START_MV / FB_LSB_MV);
  localparam logic [7:0]  ENTRY_LP_CODE = 8'(ENTRY_LP_MV / FB_LSB_MV);
  localparam logic [7:0]  ENTRY_HP_CODE = 8'(ENTRY_HP_MV / FB_LSB_MV);
  localparam logic [7:0]  LEAVE_CODE    = 8'(LEAVE_MV / FB_LSB_MV);

  // Stuck sense and option latch
  localparam logic [1:0] STUCK_LIMIT = 2'h2;
  localparam logic [1:0] OPT_SETTLE  = 2'h3;

  // Burst options
  localparam logic [1:0] OPT_NONE = 2'h1;
  localparam logic [1:0] OPT_LOW  = 2'h2;
  localparam logic [1:0] OPT_HIGH = 2'h3;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_ENTRY,
    ST_BURST_OFF,
    ST_BURST_ON
  } fpb_state_t;

  typedef struct packed {
    fpb_state_t  fsm;
    logic        burst;
    logic [15:0] blank;
    logic [1:0]  opt;
    logic        var125;
    logic        opt_done;
    logic [1:0]  opt_cnt;
    logic [15:0] cyc;
    logic [15:0] per;
    logic [15:0] on_cnt;
    logic        gate;
    logic        slope_en;
    logic [15:0] excess;
    logic        curve_hi;
    logic [1:0]  stuck;
    logic        restart;
    logic [19:0] ss_cnt;
    logic [1:0]  ss_step;
    logic        ss_done;
    logic [15:0] jit_cnt;
    logic [5:0]  tri_pos;
    logic        tri_up;
  } fpb_st_t;

endpackage

// >>> src/fpb_sync.sv
// Two-stage synchroniser for asynchronous comparator and strap levels
`timescale 1ns/1ns
`default_nettype none
module fpb_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // fpb_sync
`default_nettype wire

// >>> src/fpb_core.sv
// Flyback PWM core: oscillator, gating, soft-start, jitter and burst control
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////
module fpb_core
  import fpb_pkg::*;
#(
  parameter int unsigned LEB_CYC       = 25,
  parameter int unsigned STG_SAM_CYC   = 40,
  parameter int unsigned BEB_CYC       = 2000,
  parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
  parameter int unsigned JIT_STEP_CYCLES = JIT_STEP_CYC,
  parameter int unsigned MIN_RED_HZ    = 25_000,
  parameter int unsigned FR_SLOPE_CYC  = 60,
  parameter logic [7:0]  BURST_ON_CODE = 8'h64,
  parameter logic [7:0]  BURST_OFF_CODE = 8'h50
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Feedback level code, same clock domain
  input  wire logic [7:0]  feedback_level,
  // Asynchronous comparators and straps
  input  wire logic        pwm_cmp_async,
  input  wire logic        ilim_cmp_async,
  input  wire logic        cs_stuck_low_async,
  input  wire logic        sel_bias1_async,
  input  wire logic        sel_bias2_async,
  input  wire logic        variant_125_async,
  // Power switch
  output logic             gate_drive,
  // Current sense shaping
  output logic             slope_comp_en,
  output logic [15:0]      slope_excess,
  output logic             peak_curve_high,
  output logic             burst_limit_en,
  output logic [1:0]       soft_start_step,
  output logic             soft_start_done,
  // Status
  output logic             light_load_burst_mode,
  output logic             jitter_en,
  output logic             auto_restart_req,
  output logic [1:0]       burst_option,
  output logic [15:0]      period_cycles
);

  localparam logic [15:0] MAX_PER = 16'(CLK_HZ / MIN_RED_HZ);

  fpb_st_t    q;
  fpb_st_t    d;
  logic [5:0] s;
  logic       pwm_s;
  logic       ilim_s;
  logic       stuck_s;
  logic [7:0] entry_thr;
  logic [31:0] pb;
  logic [31:0] pj;
  logic [31:0] on_time;

  //////////////////////////////////////////////////////////////////////////////////////////
  // comparator and strap synchronisers
  fpb_sync #(
    .WIDTH    (6)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({variant_125_async, sel_bias2_async, sel_bias1_async,
                cs_stuck_low_async, ilim_cmp_async, pwm_cmp_async}),
    .sync_out (s)
  );

  assign pwm_s   = s[0];
  assign ilim_s  = s[1];
  assign stuck_s = s[2];
  assign entry_thr = (q.opt == OPT_LOW) ? ENTRY_LP_CODE : ENTRY_HP_CODE;
  assign on_time   = 32'(q.on_cnt) + 32'd1;

  //////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d         = q;
    d.restart = 1'b0;
    pb        = 32'd0;
    pj        = 32'd0;

    // option latched once, high range preset until then
    if (!q.opt_done) begin
      d.opt_cnt = q.opt_cnt + 2'h1;
      if (q.opt_cnt == OPT_SETTLE) begin
        d.opt_done = 1'b1;
        d.var125   = s[5];
        d.opt      = s[4] ? OPT_HIGH : (s[3] ? OPT_LOW : OPT_NONE);
      end
    end

    if (!q.ss_done) begin
      d.ss_cnt = q.ss_cnt + 20'h1;
      if (32'(q.ss_cnt) >= SS_STEP_CYCLES - 1) begin
        d.ss_cnt = 20'h0;
        if (q.ss_step == SS_LAST) begin
          d.ss_done = 1'b1;
        end else begin
          d.ss_step = q.ss_step + 2'h1;
        end
      end
    end

    d.jit_cnt = q.jit_cnt + 16'h1;
    if (32'(q.jit_cnt) >= JIT_STEP_CYCLES - 1) begin
      d.jit_cnt = 16'h0;
      if (q.tri_up) begin
        d.tri_pos = q.tri_pos + 6'h1;
        d.tri_up  = (q.tri_pos != TRI_MAX - 6'h1);
      end else begin
        d.tri_pos = q.tri_pos - 6'h1;
        d.tri_up  = (q.tri_pos == 6'h1);
      end
    end

    // Burst state machine
    case (q.fsm)
      ST_NORMAL: begin
        if (q.opt_done && q.opt != OPT_NONE && feedback_level < entry_thr) begin
          d.fsm   = ST_ENTRY;
          d.blank = 16'h0;
        end
      end
      ST_ENTRY: begin
        d.blank = q.blank + 16'h1;
        if (feedback_level >= entry_thr) begin
          d.fsm = ST_NORMAL;
        end else if (32'(q.blank) >= BEB_CYC - 1) begin
          d.fsm = ST_BURST_OFF;
        end
      end
      ST_BURST_OFF: begin
        if (feedback_level > LEAVE_CODE) begin
          d.fsm = ST_NORMAL;
        end else if (feedback_level > BURST_ON_CODE) begin
          d.fsm = ST_BURST_ON;
        end
      end
      ST_BURST_ON: begin
        if (feedback_level > LEAVE_CODE) begin
          d.fsm = ST_NORMAL;
        end else if (feedback_level <= BURST_OFF_CODE) begin
          d.fsm = ST_BURST_OFF;
        end
      end
      default: begin
        d.fsm = ST_NORMAL;
      end
    endcase
    d.burst = (d.fsm == ST_BURST_OFF) || (d.fsm == ST_BURST_ON);

    // nominal rate and reduction below start level
    pb = q.var125 ? 32'(NOM_PER_125) : 32'(NOM_PER_100);
    if (feedback_level < FR_START_CODE) begin
      pb = pb + 32'(FR_START_CODE - feedback_level) * FR_SLOPE_CYC;
    end
    if (pb > 32'(MAX_PER)) begin
      pb = 32'(MAX_PER);
    end
    // dither only after soft-start, also while reducing
    if (q.ss_done && !d.burst) begin
      pj = pb - pb * JIT_HALF_PCT / 100 + pb * JIT_SPAN_PCT * 32'(q.tri_pos) / (100 * 32'(TRI_MAX));
    end else begin
      pj = pb;
    end
    if (d.burst) begin
      pj = q.var125 ? 32'(BURST_PER_125) : 32'(BURST_PER_100);
    end

    if (q.cyc >= q.per - 16'h1) begin
      d.cyc    = 16'h0;
      d.per    = pj[15:0];
      d.gate   = 1'b1;
      d.on_cnt = 16'h0;
    end else begin
      d.cyc = q.cyc + 16'h1;
      if (q.gate) begin
        d.on_cnt = q.on_cnt + 16'h1;
        if (32'(q.on_cnt) >= LEB_CYC - 1) begin
          if (pwm_s) begin
            d.gate = 1'b0;
          end
          if (ilim_s) begin
            d.gate = 1'b0;
          end
        end
        if (on_time >= 32'(q.per) * MAX_DUTY_NUM / MAX_DUTY_DEN) begin
          d.gate = 1'b0;
        end
        if (32'(q.on_cnt) == STG_SAM_CYC - 1) begin
          if (stuck_s) begin
            d.stuck = q.stuck + 2'h1;
            if (q.stuck == STUCK_LIMIT) begin
              d.stuck   = 2'h0;
              d.restart = 1'b1;
            end
          end else begin
            d.stuck = 2'h0;
          end
        end
      end
    end
    if (d.fsm == ST_BURST_OFF) begin
      d.gate = 1'b0;
    end

    d.slope_en = 1'b0;
    d.excess   = 16'h0;
    if (d.gate && !q.gate) begin
      d.curve_hi = 1'b0;
    end else if (q.gate && on_time > 32'(q.per) * SLOPE_PCT / 100) begin
      d.slope_en = !d.burst;
      d.excess   = d.burst ? 16'h0 : 16'(on_time - 32'(q.per) * SLOPE_PCT / 100);
    end
    if (q.gate && on_time > 32'(q.per) * CURVE_PCT / 100) begin
      d.curve_hi = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.fsm     <= ST_NORMAL;
      q.opt     <= OPT_HIGH;
      q.per     <= NOM_PER_100;
      q.tri_up  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign gate_drive            = q.gate;
  assign slope_comp_en         = q.slope_en;
  assign slope_excess          = q.excess;
  assign peak_curve_high       = q.curve_hi;
  assign burst_limit_en        = q.burst;
  assign soft_start_step       = q.ss_step;
  assign soft_start_done       = q.ss_done;
  assign light_load_burst_mode = q.burst;
  assign jitter_en             = q.ss_done && !q.burst;
  assign auto_restart_req      = q.restart;
  assign burst_option          = q.opt;
  assign period_cycles         = q.per;

  //////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_turn_on_start:
    assert property ($rose(q.gate) |-> q.cyc == 16'h0) else $error("gate rose off cycle start");
  a_pwm_turn_off:
    assert property (q.gate && pwm_s && 32'(q.on_cnt) >= LEB_CYC - 1 && q.cyc < q.per - 16'h1 |=> !q.gate)
      else $error("pwm comparator ignored");
  a_leb_min_on:
    assert property ($fell(q.gate) && q.fsm != ST_BURST_OFF |-> 32'($past(q.on_cnt)) + 1 >= LEB_CYC)
      else $error("on-time shorter than blanking");
  a_max_duty:
    assert property (q.gate |-> 32'(q.on_cnt) * MAX_DUTY_DEN < 32'(q.per) * MAX_DUTY_NUM)
      else $error("duty above limit");
  a_stuck_restart:
    assert property ($rose(q.restart) |-> $past(q.stuck) == STUCK_LIMIT && $past(stuck_s))
      else $error("restart without three stuck pulses");
  a_freq_floor:
    assert property (!q.burst |-> 32'(q.per) * 100 <= 32'(MAX_PER) * (100 + JIT_HALF_PCT))
      else $error("period beyond floor");
  a_burst_no_slope:
    assert property (q.burst |-> !q.slope_en && q.excess == 16'h0) else $error("slope active in burst");
  a_ilim_turn_off:
    assert property (q.gate && ilim_s && 32'(q.on_cnt) >= LEB_CYC - 1 && q.cyc < q.per - 16'h1 |=> !q.gate)
      else $error("current limit ignored");
  a_entry_blank:
    assert property ($rose(q.burst) |-> $past(q.fsm) == ST_ENTRY && 32'($past(q.blank)) >= BEB_CYC - 1)
      else $error("burst entered early");
  a_burst_halt:
    assert property (q.fsm == ST_BURST_OFF |-> !q.gate) else $error("switching while halted");
  a_burst_rate:
    assert property ($rose(q.gate) && q.burst |-> q.per == (q.var125 ? BURST_PER_125 : BURST_PER_100))
      else $error("wrong burst period");
  a_leave_burst:
    assert property (q.burst && feedback_level > LEAVE_CODE |=> !q.burst && !burst_limit_en)
      else $error("burst not left");

  c_burst_entry:  cover property ($rose(q.burst));
  c_stuck_reset:  cover property ($rose(q.restart));
  c_max_duty_off: cover property ($fell(q.gate) && !pwm_s && !ilim_s);
  c_soft_done:    cover property ($rose(q.ss_done));

endmodule // fpb_core
`default_nettype wire

// >>> test/fpb_cmp_model.sv
// Behavioural comparators on the sense and feedback pins
`timescale 1ns/1ns
`default_nettype none
module fpb_cmp_model (
  // Clock and switch
  input  wire logic        core_clk,
  input  wire logic        gate_drive,
  // Scenario controls, zero means never
  input  wire logic [15:0] trip_cyc,
  input  wire logic [15:0] ilim_cyc,
  input  wire logic        stuck_low,
  // Comparator levels
  output logic             pwm_cmp_async,
  output logic             ilim_cmp_async,
  output logic             cs_stuck_low_async
);
  logic [15:0] on_cyc;
  // Sense current ramps only while the switch conducts, so both comparator levels drop as it opens and the stuck-low level rises
  initial begin
    on_cyc = 16'h0000;
    pwm_cmp_async = 1'b0;
    ilim_cmp_async = 1'b0;
    cs_stuck_low_async = 1'b1;
    forever begin
      @(negedge core_clk);
      on_cyc = gate_drive ? on_cyc + 16'h0001 : 16'h0000;
      pwm_cmp_async = gate_drive && trip_cyc != 16'h0000 && on_cyc >= trip_cyc;
      ilim_cmp_async = gate_drive && ilim_cyc != 16'h0000 && on_cyc >= ilim_cyc;
      cs_stuck_low_async = stuck_low || !gate_drive;
    end
  end
endmodule // fpb_cmp_model
`default_nettype wire

// >>> test/flyback_pwm_burst_control_bench.sv
// Self-checking bench for the flyback PWM and burst control core
`timescale 1ns/1ns
`default_nettype none
module flyback_pwm_burst_control_bench
  import fpb_pkg::*;
;
  localparam int LEB = 25;
  localparam int FR_SLOPE = 60;
  localparam int MIN_HZ = 25_000;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  feedback_level = 8'hC8;
  logic        sel_bias1 = 1'b0;
  logic        sel_bias2 = 1'b0;
  logic        variant_125 = 1'b0;
  logic        stuck_low = 1'b0;
  logic [15:0] trip_cyc = 16'h0064;
  logic [15:0] ilim_cyc = 16'h0000;
  logic        pwm_cmp, ilim_cmp, cs_stuck, gate_drive, slope_comp_en, peak_curve_high, burst_limit_en;
  logic        soft_start_done, light_load_burst_mode, jitter_en, auto_restart_req, slope_seen;
  logic [1:0]  soft_start_step, burst_option;
  logic [15:0] slope_excess, period_cycles, width, per_seen;
  int          fail_count = 0;
  int          n_compared = 0;
  int          rr_cnt = 0;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (auto_restart_req === 1'b1) rr_cnt <= rr_cnt + 1;

  fpb_cmp_model u_cmp (.core_clk(core_clk), .gate_drive(gate_drive), .trip_cyc(trip_cyc),
    .ilim_cyc(ilim_cyc), .stuck_low(stuck_low), .pwm_cmp_async(pwm_cmp),
    .ilim_cmp_async(ilim_cmp), .cs_stuck_low_async(cs_stuck));

  // Shortened soft-start, jitter step and entry blanking keep the run short
  fpb_core #(.SS_STEP_CYCLES(50), .JIT_STEP_CYCLES(4), .BEB_CYC(20), .LEB_CYC(LEB),
    .FR_SLOPE_CYC(FR_SLOPE), .MIN_RED_HZ(MIN_HZ)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .feedback_level(feedback_level),
    .pwm_cmp_async(pwm_cmp), .ilim_cmp_async(ilim_cmp), .cs_stuck_low_async(cs_stuck),
    .sel_bias1_async(sel_bias1), .sel_bias2_async(sel_bias2), .variant_125_async(variant_125),
    .gate_drive(gate_drive), .slope_comp_en(slope_comp_en), .slope_excess(slope_excess),
    .peak_curve_high(peak_curve_high), .burst_limit_en(burst_limit_en),
    .soft_start_step(soft_start_step), .soft_start_done(soft_start_done),
    .light_load_burst_mode(light_load_burst_mode), .jitter_en(jitter_en),
    .auto_restart_req(auto_restart_req), .burst_option(burst_option), .period_cycles(period_cycles));

  //////////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wait_gate(input logic lvl, input int bound);
    int i;
    i = 0;
    while (gate_drive !== lvl && i < bound) begin
      @(negedge core_clk);
      i++;
    end
    if (gate_drive !== lvl) begin
      fail_count++;
      $display("[FAIL] %0t gate wait ran out", $time);
      end_sim();
    end
  endtask

  // Measures the next whole pulse; period is taken at turn-on
  task automatic pulse();
    wait_gate(1'b0, 5000);
    wait_gate(1'b1, 5000);
    per_seen = period_cycles;
    width = 16'h0000;
    slope_seen = 1'b0;
    while (gate_drive === 1'b1 && width < 16'h1388) begin
      slope_seen = slope_seen | (slope_comp_en === 1'b1);
      @(negedge core_clk);
      width++;
    end
    if (gate_drive !== 1'b0) begin
      fail_count++;
      $display("[FAIL] %0t pulse did not end", $time);
      end_sim();
    end
  endtask

  function automatic logic in_jit(input int b);
    int lo;
    lo = b - b * JIT_HALF_PCT / 100;
    return per_seen >= lo && per_seen <= lo + b * JIT_SPAN_PCT / 100;
  endfunction

  task automatic quiet(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge core_clk);
      hi += int'(gate_drive !== 1'b0);
    end
  endtask

  task automatic do_reset(input logic b1, input logic b2, input logic v125);
    rst_b = 1'b0;
    sel_bias1 = b1;
    sel_bias2 = b2;
    variant_125 = v125;
    repeat (16) @(negedge core_clk);
    chk(32'(burst_option), 32'(OPT_HIGH), "option in reset");
    chk(32'(period_cycles), 32'(NOM_PER_100), "period in reset");
    rst_b = 1'b1;
    repeat (300) @(negedge core_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////////////
  task automatic t_options();
    do_reset(1'b0, 1'b1, 1'b1);
    chk(32'(burst_option), 32'(OPT_HIGH), "high option");
    pulse();
    chk(32'(in_jit(int'(NOM_PER_125))), 32'h1, "125k period");
    do_reset(1'b0, 1'b0, 1'b0);
    chk(32'(burst_option), 32'(OPT_NONE), "no option");
    chk({soft_start_done, soft_start_step}, 32'h7, "soft start end");
    chk(32'(jitter_en), 32'h1, "jitter after soft start");
    pulse();
    chk(32'(in_jit(int'(NOM_PER_100))), 32'h1, "100k period");
    $display("options test done");
  endtask

  task automatic t_gate();
    logic pat [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    int   rr0;
    trip_cyc = 16'h0001;
    pulse();
    chk(32'(width), LEB, "blank width");
    trip_cyc = 16'h0064;
    pulse();
    chk(32'(width >= 16'h0064 && width <= 16'h0068), 32'h1, "trip width");
    chk({slope_seen, peak_curve_high}, 32'h0, "short pulse slope");
    trip_cyc = 16'h0000;
    pulse();
    chk(32'(width), 32'(per_seen) * 3 / 4, "max duty");
    chk({slope_seen, peak_curve_high}, 32'h3, "long pulse slope");
    chk(32'(slope_excess), 32'(width) - 32'(per_seen) * SLOPE_PCT / 100, "slope excess");
    ilim_cyc = 16'h00C8;
    pulse();
    chk(32'(width >= 16'h00C8 && width <= 16'h00CC), 32'h1, "limit width");
    ilim_cyc = 16'h0000;
    trip_cyc = 16'h0064;
    rr0 = rr_cnt;
    // A healthy sample in the middle must restart the count of three
    for (int i = 0; i < 6; i++) begin
      stuck_low = pat[i];
      pulse();
      chk(32'(rr_cnt - rr0), 32'(i == 5), "restart count");
    end
    stuck_low = 1'b0;
    $display("gate test done");
  endtask

  task automatic t_freq();
    logic [7:0] fb [4] = '{8'h55, 8'h54, 8'h3C, 8'h00};
    int b;
    logic [15:0] p1;
    for (int i = 0; i < 4; i++) begin
      feedback_level = fb[i];
      b = int'(NOM_PER_100);
      if (fb[i] < FR_START_CODE) b += (int'(FR_START_CODE) - int'(fb[i])) * FR_SLOPE;
      if (b > int'(CLK_HZ) / MIN_HZ) b = int'(CLK_HZ) / MIN_HZ;
      pulse();
      p1 = per_seen;
      pulse();
      chk(32'(in_jit(b)), 32'h1, "reduced period");
    end
    chk(32'(p1 !== per_seen), 32'h1, "period dithers");
    chk(32'(light_load_burst_mode), 32'h0, "no burst");
    $display("frequency test done");
  endtask

  task automatic t_burst();
    int i;
    // A low level left from the previous test would enter burst during the settle time
    feedback_level = 8'hC8;
    do_reset(1'b1, 1'b0, 1'b0);
    chk(32'(burst_option), 32'(OPT_LOW), "low option");
    feedback_level = 8'h28;
    repeat (10) @(negedge core_clk);
    feedback_level = 8'h3C;
    repeat (30) @(negedge core_clk);
    chk(32'(light_load_burst_mode), 32'h0, "short dip");
    feedback_level = 8'h28;
    i = 0;
    while (light_load_burst_mode !== 1'b1 && i < 40) begin
      @(negedge core_clk);
      i++;
    end
    chk(32'(i >= 20 && i <= 23), 32'h1, "entry time");
    chk({burst_limit_en, gate_drive}, 32'h2, "burst limit");
    feedback_level = 8'h5A;
    quiet(1500, i);
    chk(32'(i), 32'h0, "halted");
    feedback_level = 8'h6E;
    trip_cyc = 16'h0000;
    pulse();
    chk(32'(per_seen), 32'(BURST_PER_100), "burst period");
    chk(32'(slope_seen), 32'h0, "burst slope");
    wait_gate(1'b1, 5000);
    feedback_level = 8'h46;
    @(negedge core_clk);
    chk(32'(gate_drive), 32'h0, "halt at off level");
    quiet(1500, i);
    chk(32'(i), 32'h0, "stays halted");
    feedback_level = 8'h8C;
    @(negedge core_clk);
    chk({light_load_burst_mode, burst_limit_en}, 32'h0, "leave burst");
    // High range enters at a level the low range ignores; 103 kHz burst rate of the 125 kHz variant
    feedback_level = 8'hC8;
    do_reset(1'b0, 1'b1, 1'b1);
    feedback_level = 8'h30;
    repeat (30) @(negedge core_clk);
    chk(32'(light_load_burst_mode), 32'h1, "high range entry");
    feedback_level = 8'h6E;
    pulse();
    chk(32'(per_seen), 32'(BURST_PER_125), "125k burst period");
    $display("burst test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_options();
    t_gate();
    t_freq();
    t_burst();
    end_sim();
  end
endmodule // flyback_pwm_burst_control_bench
`default_nettype wire
